// file: dv/wideband_receiver_acq_control_bench.sv
// Purpose: self-checking bench for acquisition control
// Assumes: short low-band count, far side modelled
// Notes: one task per scenario
`timescale 1ns/1ps
`include "wrac_map.svh"
module wideband_receiver_acq_control_bench;
   logic core_clk, rstn, req, we, ack, acqStart, acqEnd, trig, tick;
   logic dmaByteWr, bufferFree, recordSent;
   logic [7:0] adr, lvl;
   logic [31:0] dat, rd, q;
   wrac_pkg::wrac_eff_s cfgOut;
   int nErrors = 0, testsRun = 0, nStarts = 0;
   // free-running clock
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   wrac_acq_ctrl #(.LbandCyc(20)) i_wrac_acq_ctrl (.core_clk(core_clk),
      .rstn(rstn), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rd),
      .wb_ack_o(ack), .rtiPulse(1'b0), .trigger(trig),
      .dmaByteWr(dmaByteWr), .extSampleTick(1'b0), .agcLevel(lvl),
      .recordSent(recordSent), .bufferFree(bufferFree),
      .acqStart(acqStart), .acqEnd(acqEnd), .sampleTick(tick), .gainLoad(),
      .dustHold(), .cfgOut(cfgOut));
   wrac_far_model i_wrac_far_model (.core_clk(core_clk), .rstn(rstn),
      .acqStart(acqStart), .acqEnd(acqEnd), .dmaByteWr(dmaByteWr),
      .bufferFree(bufferFree), .recordSent(recordSent));
   // set counter
   always @(posedge core_clk)
      if (acqStart === 1'b1)
         nStarts++;
   // one classic cycle; two extra edges let the registered config catch up
   task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      req <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do @(posedge core_clk); while (ack !== 1'b1);
      q = rd;
      req <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp)
      begin
         $display("Error %0t: got %h want %h", $time, got, exp);
         nErrors++;
      end
   endtask
   task automatic t_sync();
      wb(1'b1, `WRAC_A_CMPRS, 32'h1400_0003);
      chk(32'(cfgOut.cmp), 32'h7400);
      wb(1'b1, `WRAC_A_CMPRS, 32'h0fff_0001);
      wb(1'b1, `WRAC_A_MODE, 32'h1);
      wb(1'b1, `WRAC_A_SYNC, 32'h1);
      chk(32'(cfgOut.cmp), 32'h0800);
      wb(1'b1, `WRAC_A_SYNC, 32'h0);
      chk(32'(cfgOut.cmp), 32'h4fff);
   endtask
   task automatic t_cfg();
      for (int a = 0; a < 5; a++)
      begin
         wb(1'b1, `WRAC_A_MODE, 32'(a << 4));
         wb(1'b1, `WRAC_A_GAIN, 32'(a << 4));
         wb(1'b1, `WRAC_A_DEST, 32'(a & 1));
         chk(32'(cfgOut.extraStatus), 32'(a >= 3));
         chk(32'(cfgOut.gain), 32'(a));
         chk(32'(cfgOut.destHrs), 32'(a & 1));
         chk(32'(cfgOut.bandHigh), 32'h0);
      end
   endtask
   task automatic t_burst();
      wb(1'b1, `WRAC_A_CMPRS, 32'h0010_0000);
      wb(1'b1, `WRAC_A_PERIOD, 32'h0);
      wb(1'b1, `WRAC_A_SCHED, 32'h2);
      wb(1'b1, `WRAC_A_BURST, 32'h0005_0009);
      wb(1'b1, `WRAC_A_SCHED, 32'h1);
      wb(1'b0, `WRAC_A_BURST, 32'h0);
      chk(q, 32'h0);
      wb(1'b1, `WRAC_A_BURST, 32'h0003_0008);
      repeat (40) @(posedge core_clk);
      nStarts = 0;
      wb(1'b0, `WRAC_A_BURST, 32'h0);
      chk(q, 32'h0003_0000);
      wb(1'b1, `WRAC_A_BURST, 32'h0000_0003);
      wb(1'b0, `WRAC_A_STAT, 32'h0);
      chk(32'(q[10]), 32'h1);
      repeat (300)
      begin
         wb(1'b0, `WRAC_A_SCHED, 32'h0);
         if (q[3:0] === 4'h1)
            break;
      end
      chk(32'(q[3:0]), 32'h1);
      chk(32'(nStarts), 32'h3);
   endtask
   // low level raises gain once, then skip and holdoff gate the next step
   task automatic t_agc();
      wb(1'b1, `WRAC_A_GAIN, 32'h31);
      lvl <= 8'h10;
      nStarts = 0;
      for (int i = 0; i < 7; i++)
      begin
         trig <= 1'b1;
         @(posedge core_clk);
         trig <= 1'b0;
         repeat (40) @(posedge core_clk);
         if (i == 0 || i == 5)
            chk(32'(cfgOut.gain), 32'h4);
      end
      chk(32'(cfgOut.gain), 32'h5);
      chk(32'(nStarts), 32'h7);
      wb(1'b0, `WRAC_A_SCHED, 32'h0);
      chk(q, 32'h1);
   endtask
   // period shifts, then tick spacing in both bands
   task automatic t_rate();
      int n;
      wb(1'b1, `WRAC_A_PERIOD, 32'h6);
      wb(1'b1, `WRAC_A_RATE, 32'h1);
      wb(1'b0, `WRAC_A_PERIOD, 32'h0);
      chk(q, 32'hc);
      wb(1'b1, `WRAC_A_RATE, 32'h0);
      wb(1'b1, `WRAC_A_RATE, 32'h0);
      wb(1'b0, `WRAC_A_PERIOD, 32'h0);
      chk(q, 32'h3);
      for (int b = 0; b < 2; b++)
      begin
         wb(1'b1, `WRAC_A_MODE, 32'(b));
         do @(posedge core_clk); while (tick !== 1'b1);
         n = 0;
         do
         begin
            @(posedge core_clk);
            n++;
         end
         while (tick !== 1'b1);
         chk(32'(n), b ? 32'(`WRAC_HBAND_CYC) : 32'h14);
      end
   endtask
   task automatic wrap_up();
      $display("errors %0d checks %0d", nErrors, testsRun);
      if (nErrors == 0 && testsRun > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // stuck handshake guard
   initial
   begin
      #60us;
      nErrors++;
      wrap_up();
   end
   initial
   begin
      {rstn, req, we, trig, adr, dat} = '0;
      lvl = 8'h80;
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      t_sync();
      t_cfg();
      t_burst();
      t_agc();
      t_rate();
      wrap_up();
   end
endmodule // wideband_receiver_acq_control_bench

// file: dv/wrac_far_model.sv
// Purpose: far side model, dma byte stream and buffer returns
// Assumes: one byte per cycle while a set runs
// Notes: buffers come back three cycles after a set ends
`timescale 1ns/1ps
module wrac_far_model
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // acquisition control in
   input wire logic acqStart,
   input wire logic acqEnd,
   // events out
   output logic dmaByteWr,
   output logic bufferFree,
   output logic recordSent
);
   logic busy_r;
   logic [2:0] retire_r;
   // bytes flow only inside a set, so stray strobes never pad a count
   always_ff @(posedge core_clk or negedge rstn)
      if (!rstn)
      begin
         busy_r <= 1'b0;
         retire_r <= 3'h0;
      end
      else
      begin
         busy_r <= (busy_r | acqStart) & ~acqEnd;
         retire_r <= {retire_r[1:0], acqEnd};
      end
   // quick return keeps the two-buffer limit out of reach
   assign dmaByteWr = busy_r;
   assign bufferFree = retire_r[2];
   assign recordSent = retire_r[2];
endmodule // wrac_far_model

// file: inc/wrac_map.svh
// Purpose: offsets, field positions, reset values and timing of acq control
// Assumes: 32-bit Wishbone words, byte addresses
// Notes: definitions only
`ifndef WRAC_MAP_SVH
`define WRAC_MAP_SVH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define WRAC_A_SCHED 8'h00
`define WRAC_A_BURST 8'h04
`define WRAC_A_CMPRS 8'h08
`define WRAC_A_DEST 8'h0c
`define WRAC_A_GAIN 8'h10
`define WRAC_A_MODE 8'h14
`define WRAC_A_TRIP 8'h18
`define WRAC_A_RATE 8'h1c
`define WRAC_A_PERIOD 8'h20
`define WRAC_A_SYNC 8'h24
`define WRAC_A_STAT 8'h28
`define WRAC_A_DESC 8'h2c
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define WRAC_B_EN 0
`define WRAC_B_NODUST 1
`define WRAC_B_CDS 2
`define WRAC_B_TWO 3
`define WRAC_B_CNT 16
`define WRAC_C_EN 0
`define WRAC_C_EXT 1
`define WRAC_C_SIZE 16
`define WRAC_G_AUTO 0
`define WRAC_G_LVL 4
`define WRAC_M_HIGH 0
`define WRAC_M_ANT 4
`define WRAC_M_TRIG 8
`define WRAC_T_LOW 0
`define WRAC_T_HIGH 8
`define WRAC_T_HOLD 16
`define WRAC_R_LEFT 0
`define WRAC_S_LF 0
// ------------------------------------------------------------
// reset values and limits
// ------------------------------------------------------------
`define WRAC_SIZE_RST 13'h0800
`define WRAC_PER_RST 16'h0001
`define WRAC_TLOW_RST 8'h40
`define WRAC_THIGH_RST 8'hc0
`define WRAC_HOLD_RST 8'h04
`define WRAC_SIZE_MAX 13'h1400
`define WRAC_SYNC_MAX 13'h0800
`define WRAC_GAIN_TOP 3'h7
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define WRAC_CLK_MHZ 250
`define WRAC_LBAND_NS 36000
`define WRAC_HBAND_NS 4500
`define WRAC_HBAND_CYC (`WRAC_HBAND_NS * `WRAC_CLK_MHZ / 1000)
`endif

// file: inc/wrac_pkg.sv
// Purpose: types shared by the acquisition control files
// Assumes: nothing
// Notes: numbers live in wrac_map.svh
package wrac_pkg;
   // acquisition sequencer, gray along idle-arm-capture-done
   typedef enum logic [1:0] {AQ_IDLE = 2'b00, AQ_ARM = 2'b01,
      AQ_CAPT = 2'b11, AQ_DONE = 2'b10} wrac_aq_e;
   // scheduling modes
   typedef enum logic [3:0] {M_STOP = 4'h0, M_IDLE = 4'h1, M_RUN = 4'h2,
      M_TRIG = 4'h3, M_BURST = 4'h8, M_BURST_ND = 4'h9, M_CDS = 4'ha,
      M_CDS_ND = 4'hb, M_INT = 4'hc, M_INT_ND = 4'hd} wrac_mode_e;
   // antenna inputs
   typedef enum logic [2:0] {ANT_DIPOLE_X = 3'h0, ANT_MONOPOLE_Z = 3'h1,
      ANT_SEARCH_COIL = 3'h2, ANT_DOWNCONV = 3'h3,
      ANT_PROBE = 3'h4} wrac_ant_e;
   typedef struct packed {
      logic compress;
      logic extRoute;
      logic [12:0] size;
   } wrac_cmp_s;
   typedef struct packed {
      wrac_cmp_s cmp;
      logic bandHigh;
      wrac_ant_e antenna;
      logic extraStatus;
      logic [2:0] gain;
      logic destHrs;
   } wrac_eff_s;
   typedef struct packed {
      logic [2:0] gain;
      logic compress;
      logic [12:0] size;
   } wrac_desc_s;
endpackage

// file: logic/wrac_acq_ctrl.sv
// Purpose: command-driven acquisition control for the wideband receiver
// Assumes: Wishbone classic slave, all acquisition strobes synchronous
// Notes: data sets leave by DMA into two buffers, tracked here only
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "wrac_map.svh"

// Summary of operation
// - burst commands act only in idle scheduling mode, else ignored
// - two-word burst sets new count; one-word reuses the stored count
// - burst with enable clear only stores the count, captures nothing
// - nodust holds dust acquisitions while a burst runs; dust lets them go
// - target counts data sets or records; record mode lets in-flight finish
// - two buffers may still drain after a record-counted burst ends
// - compression command switches the compressor on or off
// - route picks DMA count alone or also the external sample count
// - DMA counter always counts bytes written, compressed or not
// - low-frequency sync forces compression off
// - sync plus high band caps the data-set size at 2048
// - overrides leave the commanded settings untouched and restorable
// - destination command selects low-rate or high-rate science stream
// - gain command picks manual or auto and a 0..70 dB level
// - band sets the sample period, 36 us low or 4.5 us high
// - downconverter or probe antenna raises the extra-status flag
// - auto gain compares level after each data set with trip points
// - an auto gain decision is loaded into the receiver at once
// - gain update is skipped on every other acquisition
// - after a change, updates wait the commanded number of data sets
// - rate throttle shifts the scheduling period one bit left or right
// - idle mode runs one acquisition per trigger, then stays idle
module wrac_acq_ctrl
#(
   parameter int LbandCyc = `WRAC_LBAND_NS * `WRAC_CLK_MHZ / 1000
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // acquisition events in
   input wire logic rtiPulse,
   input wire logic trigger,
   input wire logic dmaByteWr,
   input wire logic extSampleTick,
   input wire logic [7:0] agcLevel,
   input wire logic recordSent,
   input wire logic bufferFree,
   // acquisition control out
   output logic acqStart,
   output logic acqEnd,
   output logic sampleTick,
   output logic gainLoad,
   output logic dustHold,
   output wrac_pkg::wrac_eff_s cfgOut
);
   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic wbAck_r;
   logic [31:0] wbDat_r;
   wrac_pkg::wrac_mode_e modeReg_r, modeNxt;
   wrac_pkg::wrac_aq_e aq_r, aqNxt;
   wrac_pkg::wrac_cmp_s cmp_r;
   wrac_pkg::wrac_ant_e antenna_r;
   wrac_pkg::wrac_eff_s eff;
   wrac_pkg::wrac_eff_s cfg_r;
   wrac_pkg::wrac_desc_s descRd;
   logic [15:0] burstCnt_r, burstRun_r, period_r, periodCnt_r;
   logic burstCds_r, destHrs_r, gainAuto_r, bandHigh_r, lfSync_r;
   logic [2:0] gainCode_r;
   logic [7:0] tripLow_r, tripHigh_r, holdCfg_r, hold_r;
   logic [1:0] bufOut_r;
   logic bufSel_r, skip_r, trigPend_r;
   logic [12:0] byteCnt_r, sampCnt_r, sizeIn;
   logic [13:0] divCnt_r;
   logic [31:0] rdMux;

   // ------------------------------------------------------------
   // wishbone decode
   // ------------------------------------------------------------
   // writes land on the ack edge; partial-lane writes are acked, dropped
   wire wbReq = wb_cyc_i & wb_stb_i;
   wire wrEn = wbReq & wb_we_i & wbAck_r & (wb_sel_i == 4'hf);
   wire wrSched = wrEn & (wb_adr_i == `WRAC_A_SCHED);
   wire wrBurst = wrEn & (wb_adr_i == `WRAC_A_BURST);
   wire wrCmprs = wrEn & (wb_adr_i == `WRAC_A_CMPRS);
   wire wrDest = wrEn & (wb_adr_i == `WRAC_A_DEST);
   wire wrGain = wrEn & (wb_adr_i == `WRAC_A_GAIN);
   wire wrMode = wrEn & (wb_adr_i == `WRAC_A_MODE);
   wire wrTrip = wrEn & (wb_adr_i == `WRAC_A_TRIP);
   wire wrRate = wrEn & (wb_adr_i == `WRAC_A_RATE);
   wire wrPeriod = wrEn & (wb_adr_i == `WRAC_A_PERIOD);
   wire wrSync = wrEn & (wb_adr_i == `WRAC_A_SYNC);
   wire [15:0] cmdCnt = wb_dat_i[`WRAC_B_CNT +: 16];

   // ------------------------------------------------------------
   // burst and scheduling mode decode
   // ------------------------------------------------------------
   wire isIdle = (modeReg_r == wrac_pkg::M_IDLE);
   wire burstOk = wrBurst & isIdle;
   wire burstTwo = burstOk & wb_dat_i[`WRAC_B_TWO];
   wire burstGo = burstOk & wb_dat_i[`WRAC_B_EN];
   wire schedLoad = wrSched & wb_dat_i[3] & ~wb_dat_i[2];
   wire inBurst = (modeReg_r == wrac_pkg::M_INT) |
      (modeReg_r == wrac_pkg::M_INT_ND);
   wire burstEnd = inBurst & (burstRun_r == 16'h0000);
   wire runMode = (modeReg_r == wrac_pkg::M_RUN) | (inBurst & ~burstEnd);
   wire canStart = (bufOut_r != 2'h2);
   wire [16:0] perNext = {1'b0, periodCnt_r} + 17'h00001;
   // period zero means immediate scheduling
   wire schedGo = (period_r == 16'h0000) |
      (rtiPulse & (perNext >= {1'b0, period_r}));
   wire trigStart = (aq_r == wrac_pkg::AQ_IDLE) & canStart &
      (trigPend_r | (modeReg_r == wrac_pkg::M_TRIG));
   wire startNow = trigStart |
      ((aq_r == wrac_pkg::AQ_ARM) & runMode & schedGo & canStart);
   wire aqDone = (aq_r == wrac_pkg::AQ_DONE);
   // record target counts deliveries, so in-flight sets still finish
   wire burstDec = inBurst & ~burstEnd &
      (burstCds_r ? recordSent : aqDone);
   wire trigIn = isIdle & (trigger |
      (wrMode & wb_dat_i[`WRAC_M_TRIG]));

   // next scheduling mode, a software write wins over internal changes
   always_comb
   begin
      modeNxt = modeReg_r;
      if (burstEnd | (trigStart & ~trigPend_r))
         modeNxt = wrac_pkg::M_IDLE;
      if (burstGo)
         modeNxt = wb_dat_i[`WRAC_B_NODUST] ? wrac_pkg::M_INT_ND
            : wrac_pkg::M_INT;
      if (wrSched)
         modeNxt = wrac_pkg::wrac_mode_e'(wb_dat_i[3:0]);
      if (schedLoad)
         modeNxt = wb_dat_i[0] ? wrac_pkg::M_INT_ND : wrac_pkg::M_INT;
   end

   // mode and burst counters; an abort leaves the run count alone
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         modeReg_r <= wrac_pkg::M_IDLE;
         burstCnt_r <= 16'h0000;
         burstRun_r <= 16'h0000;
         burstCds_r <= 1'b0;
      end
      else
      begin
         modeReg_r <= modeNxt;
         if (burstTwo)
            burstCnt_r <= cmdCnt;
         if (burstGo)
         begin
            burstRun_r <= burstTwo ? cmdCnt : burstCnt_r;
            burstCds_r <= wb_dat_i[`WRAC_B_CDS];
         end
         else if (schedLoad)
         begin
            burstRun_r <= burstCnt_r;
            burstCds_r <= wb_dat_i[1];
         end
         else if (burstDec)
            burstRun_r <= burstRun_r - 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // commanded settings
   // ------------------------------------------------------------
   // oversize requests saturate at the buffer limit
   assign sizeIn = (wb_dat_i[`WRAC_C_SIZE +: 13] > `WRAC_SIZE_MAX) ?
      `WRAC_SIZE_MAX : wb_dat_i[`WRAC_C_SIZE +: 13];

   // command registers, software owns them outright
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cmp_r <= '{compress: 1'b0, extRoute: 1'b0, size: `WRAC_SIZE_RST};
         destHrs_r <= 1'b0;
         bandHigh_r <= 1'b0;
         antenna_r <= wrac_pkg::ANT_DIPOLE_X;
         lfSync_r <= 1'b0;
         tripLow_r <= `WRAC_TLOW_RST;
         tripHigh_r <= `WRAC_THIGH_RST;
         holdCfg_r <= `WRAC_HOLD_RST;
      end
      else
      begin
         if (wrCmprs)
            cmp_r <= '{compress: wb_dat_i[`WRAC_C_EN],
               extRoute: wb_dat_i[`WRAC_C_EXT], size: sizeIn};
         if (wrDest)
            destHrs_r <= wb_dat_i[0];
         if (wrMode)
         begin
            bandHigh_r <= wb_dat_i[`WRAC_M_HIGH];
            antenna_r <= wrac_pkg::wrac_ant_e'(wb_dat_i[`WRAC_M_ANT +: 3]);
         end
         if (wrSync)
            lfSync_r <= wb_dat_i[`WRAC_S_LF];
         if (wrTrip)
         begin
            tripLow_r <= wb_dat_i[`WRAC_T_LOW +: 8];
            tripHigh_r <= wb_dat_i[`WRAC_T_HIGH +: 8];
            holdCfg_r <= wb_dat_i[`WRAC_T_HOLD +: 8];
         end
      end
   end

   // ------------------------------------------------------------
   // effective settings, overrides never touch the commanded copy
   // ------------------------------------------------------------
   wire syncHigh = lfSync_r & bandHigh_r;
   assign eff.cmp.compress = cmp_r.compress & ~lfSync_r;
   assign eff.cmp.extRoute = cmp_r.extRoute;
   assign eff.cmp.size = (syncHigh & (cmp_r.size > `WRAC_SYNC_MAX)) ?
      `WRAC_SYNC_MAX : cmp_r.size;
   assign eff.bandHigh = bandHigh_r;
   assign eff.antenna = antenna_r;
   assign eff.extraStatus = lfSync_r |
      (antenna_r == wrac_pkg::ANT_DOWNCONV) |
      (antenna_r == wrac_pkg::ANT_PROBE);
   assign eff.gain = gainCode_r;
   assign eff.destHrs = destHrs_r;

   // ------------------------------------------------------------
   // automatic gain
   // ------------------------------------------------------------
   // a skipped set stops a queued buffer from doubling the step
   wire agcEval = aqDone & gainAuto_r & ~skip_r &
      (hold_r == 8'h00);
   wire agcUp = agcEval & (agcLevel < tripLow_r) &
      (gainCode_r != `WRAC_GAIN_TOP);
   wire agcDn = agcEval & ~agcUp & (agcLevel > tripHigh_r) &
      (gainCode_r != 3'h0);
   wire agcChange = agcUp | agcDn;
   assign gainLoad = agcChange | wrGain;

   // gain state, a manual write wins over a same-cycle decision
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         gainAuto_r <= 1'b0;
         gainCode_r <= 3'h0;
         skip_r <= 1'b0;
         hold_r <= 8'h00;
      end
      else
      begin
         if (aqDone & gainAuto_r)
            skip_r <= ~skip_r;
         if (agcChange)
            hold_r <= holdCfg_r;
         else if (aqDone & (hold_r != 8'h00))
            hold_r <= hold_r - 8'h01;
         if (wrGain)
         begin
            gainAuto_r <= wb_dat_i[`WRAC_G_AUTO];
            gainCode_r <= wb_dat_i[`WRAC_G_LVL +: 3];
         end
         else if (agcUp)
            gainCode_r <= gainCode_r + 3'h1;
         else if (agcDn)
            gainCode_r <= gainCode_r - 3'h1;
      end
   end

   // ------------------------------------------------------------
   // acquisition sequencer
   // ------------------------------------------------------------
   // byte counter ends every set; external sample count may end it first
   assign acqEnd = (aq_r == wrac_pkg::AQ_CAPT) &
      ((byteCnt_r >= eff.cmp.size) |
      (eff.cmp.extRoute & (sampCnt_r >= eff.cmp.size)));
   assign acqStart = startNow;

   always_comb
   begin
      case (aq_r)
         wrac_pkg::AQ_IDLE:
            aqNxt = trigStart ? wrac_pkg::AQ_CAPT
               : (runMode ? wrac_pkg::AQ_ARM : wrac_pkg::AQ_IDLE);
         wrac_pkg::AQ_ARM:
            aqNxt = startNow ? wrac_pkg::AQ_CAPT
               : (runMode ? wrac_pkg::AQ_ARM : wrac_pkg::AQ_IDLE);
         wrac_pkg::AQ_CAPT:
            aqNxt = acqEnd ? wrac_pkg::AQ_DONE : wrac_pkg::AQ_CAPT;
         wrac_pkg::AQ_DONE:
            aqNxt = wrac_pkg::AQ_IDLE;
         default:
            aqNxt = wrac_pkg::AQ_IDLE;
      endcase
   end

   // sequencer, counters and buffer bookkeeping
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         aq_r <= wrac_pkg::AQ_IDLE;
         byteCnt_r <= 13'h0000;
         sampCnt_r <= 13'h0000;
         periodCnt_r <= 16'h0000;
         bufOut_r <= 2'h0;
         bufSel_r <= 1'b0;
         trigPend_r <= 1'b0;
      end
      else
      begin
         aq_r <= aqNxt;
         byteCnt_r <= startNow ? 13'h0000 : byteCnt_r +
            13'({12'h000, dmaByteWr & (aq_r == wrac_pkg::AQ_CAPT)});
         sampCnt_r <= startNow ? 13'h0000 : sampCnt_r +
            13'({12'h000, extSampleTick & (aq_r == wrac_pkg::AQ_CAPT)});
         if (startNow)
            periodCnt_r <= 16'h0000;
         else if ((aq_r == wrac_pkg::AQ_ARM) & rtiPulse)
            periodCnt_r <= perNext[15:0];
         if (startNow & ~bufferFree)
            bufOut_r <= bufOut_r + 2'h1;
         else if (bufferFree & ~startNow & (bufOut_r != 2'h0))
            bufOut_r <= bufOut_r - 2'h1;
         if (startNow)
            bufSel_r <= ~bufSel_r;
         // a trigger arriving as the pending one is taken is kept
         trigPend_r <= trigIn | (trigPend_r & ~trigStart);
      end
   end

   // ------------------------------------------------------------
   // scheduling period, sample rate and outputs
   // ------------------------------------------------------------
   wire [13:0] divLast = bandHigh_r ? 14'(`WRAC_HBAND_CYC - 1)
      : 14'(LbandCyc - 1);
   assign sampleTick = (divCnt_r >= divLast);
   assign dustHold = inBurst & (modeReg_r == wrac_pkg::M_INT_ND);

   // divider restarts on band change so no long tick is seen
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         divCnt_r <= 14'h0000;
         period_r <= `WRAC_PER_RST;
         cfg_r <= '0;
      end
      else
      begin
         divCnt_r <= (sampleTick | wrMode) ? 14'h0000 : divCnt_r + 14'h0001;
         if (wrPeriod)
            period_r <= wb_dat_i[15:0];
         else if (wrRate)
            period_r <= wb_dat_i[`WRAC_R_LEFT] ? {period_r[14:0], 1'b0}
               : {1'b0, period_r[15:1]};
         cfg_r <= eff;
      end
   end
   assign cfgOut = cfg_r;

   // descriptor of each started buffer, read back for the last one
   wrac_desc_mem uDesc
   (
      .core_clk(core_clk),
      .rstn(rstn),
      .we(startNow),
      .wrSel(bufSel_r),
      .wrData({eff.gain, eff.cmp.compress, eff.cmp.size}),
      .rdSel(~bufSel_r),
      .rdData(descRd)
   );

   // ------------------------------------------------------------
   // read mux and bus answer
   // ------------------------------------------------------------
   always_comb
   begin
      case (wb_adr_i)
         `WRAC_A_SCHED: rdMux = {28'h0000000, modeReg_r};
         `WRAC_A_BURST: rdMux = {burstCnt_r, 12'h000, 1'b0, burstCds_r,
            2'h0};
         `WRAC_A_CMPRS: rdMux = {3'h0, cmp_r.size, 14'h0000,
            cmp_r.extRoute, cmp_r.compress};
         `WRAC_A_DEST: rdMux = {31'h00000000, destHrs_r};
         `WRAC_A_GAIN: rdMux = {25'h0000000, gainCode_r, 3'h0, gainAuto_r};
         `WRAC_A_MODE: rdMux = {25'h0000000, antenna_r, 3'h0, bandHigh_r};
         `WRAC_A_TRIP: rdMux = {8'h00, holdCfg_r, tripHigh_r, tripLow_r};
         `WRAC_A_PERIOD: rdMux = {16'h0000, period_r};
         `WRAC_A_SYNC: rdMux = {31'h00000000, lfSync_r};
         `WRAC_A_STAT: rdMux = {burstRun_r, eff.cmp.compress, gainCode_r,
            eff.extraStatus, dustHold, bufOut_r, modeReg_r, 2'h0, aq_r};
         `WRAC_A_DESC: rdMux = {15'h0000, descRd};
         default: rdMux = 32'h00000000;
      endcase
   end

   // one wait cycle, ack for one cycle, unmapped reads give zero
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wbAck_r <= 1'b0;
         wbDat_r <= 32'h00000000;
      end
      else
      begin
         wbAck_r <= wbReq & ~wbAck_r;
         if (wbReq & ~wbAck_r)
            wbDat_r <= rdMux;
      end
   end
   assign wb_ack_o = wbAck_r;
   assign wb_dat_o = wbDat_r;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   burst_idle_a: assert property (wrBurst & !isIdle & !burstDec |=>
      $stable(burstCnt_r) && $stable(burstRun_r))
      else $error("burst command acted outside idle");
   size_only_a: assert property (burstTwo & !burstGo |=>
      modeReg_r == wrac_pkg::M_IDLE && burstCnt_r == $past(cmdCnt))
      else $error("size-only burst started capture");
   sync_nocomp_a: assert property (lfSync_r |->
      !eff.cmp.compress && (!$past(lfSync_r) || !cfgOut.cmp.compress))
      else $error("compression active in sync");
   sync_cap_a: assert property (syncHigh |->
      eff.cmp.size <= `WRAC_SYNC_MAX)
      else $error("data set size above sync cap");
   extra_flag_a: assert property (wrMode &&
      wb_dat_i[`WRAC_M_ANT +: 3] == 3'h4 |=> ##1 cfgOut.extraStatus)
      else $error("extra status not raised");
   gain_hold_a: assert property (agcChange |=>
      hold_r == $past(holdCfg_r) && skip_r)
      else $error("gain holdoff not loaded");
   gain_step_a: assert property (agcChange && !wrGain |=>
      gainCode_r != $past(gainCode_r) && $past(gainLoad))
      else $error("gain decision not applied");
   rate_shift_a: assert property (wrRate && !wrPeriod &&
      wb_dat_i[0] |=> period_r == {$past(period_r[14:0]), 1'b0})
      else $error("period not shifted left");
   dust_hold_a: assert property (burstGo && wb_dat_i[`WRAC_B_NODUST]
      |=> dustHold)
      else $error("dust not held in nodust burst");
   buf_max_a: assert property (bufOut_r == 2'h2 |-> !startNow)
      else $error("third buffer started");
endmodule // wrac_acq_ctrl

// file: logic/wrac_desc_mem.sv
// Purpose: per-buffer descriptor store for the two acquisition buffers
// Assumes: one write port, one registered read port
// Notes: read data lag the address by one cycle
`timescale 1ns/1ps
module wrac_desc_mem
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // write side
   input wire logic we,
   input wire logic wrSel,
   input wrac_pkg::wrac_desc_s wrData,
   // read side
   input wire logic rdSel,
   output wrac_pkg::wrac_desc_s rdData
);
   wrac_pkg::wrac_desc_s mem [2];

   // storage has no reset, contents are only meaningful once written
   always_ff @(posedge core_clk)
   begin
      if (we)
         mem[wrSel] <= wrData;
   end

   // registered read
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         rdData <= '0;
      else
         rdData <= mem[rdSel];
   end
endmodule // wrac_desc_mem
